// ### port_pin_state_defs.vh
`ifndef PORT_PIN_STATE_DEFS_VH
`define PORT_PIN_STATE_DEFS_VH

// Port geometry
`define PORT_W             8
`define PORT_RESET         8'h00
`define AVS_ADDR_W         18
`define AVS_DATA_W         32
`define AVS_PAD            24'h000000
`define REG_IDX_W          16

// Register indices, byte address is four times the index
`define PORT_DIRECTION_IDX   16'hFEB1
`define PORT_PIN_STATE_IDX   16'hFF51
`define PORT_OUTPUT_DATA_IDX 16'hFF61
`define PIN_FUNCTION_IDX     16'hFF71

// Pin positions of the timer functions
`define BIT_T1_COMPARE     7
`define BIT_T0_COMPARE     6
`define BIT_T1_EXT_CLOCK   5
`define BIT_T1_CNT_RESET   4
`define BIT_T0_EXT_CLOCK   3
`define BIT_T0_CNT_RESET   2

// Timer control field widths and codes
`define OS_W               4
`define OS_ALL_ZERO        4'h0
`define CKS_W              3
`define CKS_EXT_FIRST      3'h5
`define CCLR_W             2
`define CCLR_EXT_RESET     2'h3

`endif

// ### avalon_port_slave.v
`include "port_pin_state_defs.vh"

module avalon_port_slave (
	// Clock and reset
	input  wire                     i_ref_clk,
	input  wire                     i_sys_rst,
	// Avalon-MM slave
	input  wire [`AVS_ADDR_W-1:0]   i_avs_address,
	input  wire                     i_avs_read,
	input  wire                     i_avs_write,
	input  wire [`AVS_DATA_W-1:0]   i_avs_writedata,
	output wire                     o_avs_waitrequest,
	output wire [`AVS_DATA_W-1:0]   o_avs_readdata,
	// Register side
	input  wire [`PORT_W-1:0]       i_pin_state,
	input  wire [`PORT_W-1:0]       i_output_data,
	input  wire [`PORT_W-1:0]       i_pin_function,
	output wire                     o_dir_we,
	output wire                     o_data_we,
	output wire [`PORT_W-1:0]       o_wr_byte
);

	reg                     ack_reg;
	reg [`AVS_DATA_W-1:0]   readdata_reg;
	reg [`PORT_W-1:0]       rd_byte;
	wire                    req;

	function hit;
		input [`AVS_ADDR_W-1:0] addr;
		input [`REG_IDX_W-1:0]  idx;
		begin
			hit = (addr == {idx, 2'b00});
		end
	endfunction

	assign req               = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_reg;
	assign o_avs_readdata    = readdata_reg;
	assign o_wr_byte         = i_avs_writedata[`PORT_W-1:0];
	assign o_dir_we  = i_avs_write & ack_reg & hit(i_avs_address, `PORT_DIRECTION_IDX);
	assign o_data_we = i_avs_write & ack_reg & hit(i_avs_address, `PORT_OUTPUT_DATA_IDX);

	// Read mux, direction reads as zero, writes to pin state dropped
	always @* begin
		rd_byte = `PORT_RESET;
		if (hit(i_avs_address, `PORT_PIN_STATE_IDX)) begin
			rd_byte = i_pin_state; // [R8]
		end else if (hit(i_avs_address, `PORT_OUTPUT_DATA_IDX)) begin
			rd_byte = i_output_data; // [R5]
		end else if (hit(i_avs_address, `PIN_FUNCTION_IDX)) begin
			rd_byte = i_pin_function;
		end else if (hit(i_avs_address, `PORT_DIRECTION_IDX)) begin
			rd_byte = `PORT_RESET; // [R2]
		end
	end

	// One wait state per access
	always @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			ack_reg      <= 1'b0;
			readdata_reg <= {`AVS_PAD, `PORT_RESET};
		end else begin
			ack_reg <= req & ~ack_reg;
			if (i_avs_read & ~ack_reg) begin
				readdata_reg <= {`AVS_PAD, rd_byte};
			end
		end
	end

endmodule // avalon_port_slave

// ### timer_pin_mux.v
`include "port_pin_state_defs.vh"

module timer_pin_mux (
	// Port registers and pins
	input  wire [`PORT_W-1:0]  i_dir,
	input  wire [`PORT_W-1:0]  i_data,
	input  wire [`PORT_W-1:0]  i_pin_in,
	// Timer settings
	input  wire                i_timers_live,
	input  wire [`OS_W-1:0]    i_t0_output_select,
	input  wire [`OS_W-1:0]    i_t1_output_select,
	input  wire [`CKS_W-1:0]   i_t0_clock_select,
	input  wire [`CKS_W-1:0]   i_t1_clock_select,
	input  wire [`CCLR_W-1:0]  i_t0_counter_clear,
	input  wire [`CCLR_W-1:0]  i_t1_counter_clear,
	input  wire                i_t0_compare_out,
	input  wire                i_t1_compare_out,
	// Resolved pin function
	output reg  [`PORT_W-1:0]  o_pin_out,
	output reg  [`PORT_W-1:0]  o_pin_oe,
	output reg  [`PORT_W-1:0]  o_function,
	output wire                o_t0_ext_clock,
	output wire                o_t1_ext_clock,
	output wire                o_t0_cnt_reset,
	output wire                o_t1_cnt_reset
);

	wire t0_cmp_on;
	wire t1_cmp_on;
	wire t0_clk_on;
	wire t1_clk_on;
	wire t0_rst_on;
	wire t1_rst_on;

	function ext_clock;
		input [`CKS_W-1:0] cks;
		begin
			ext_clock = (cks >= `CKS_EXT_FIRST);
		end
	endfunction

	function ext_reset;
		input [`CCLR_W-1:0] cclr;
		begin
			ext_reset = (cclr == `CCLR_EXT_RESET);
		end
	endfunction

	assign t1_cmp_on = i_timers_live & (i_t1_output_select != `OS_ALL_ZERO); // [R11]
	assign t0_cmp_on = i_timers_live & (i_t0_output_select != `OS_ALL_ZERO); // [R11]
	assign t1_clk_on = i_timers_live & ext_clock(i_t1_clock_select); // [R12]
	assign t0_clk_on = i_timers_live & ext_clock(i_t0_clock_select); // [R12]
	assign t1_rst_on = i_timers_live & ext_reset(i_t1_counter_clear); // [R13]
	assign t0_rst_on = i_timers_live & ext_reset(i_t0_counter_clear); // [R13]

	assign o_t1_ext_clock = t1_clk_on & i_pin_in[`BIT_T1_EXT_CLOCK];
	assign o_t0_ext_clock = t0_clk_on & i_pin_in[`BIT_T0_EXT_CLOCK];
	assign o_t1_cnt_reset = t1_rst_on & i_pin_in[`BIT_T1_CNT_RESET];
	assign o_t0_cnt_reset = t0_rst_on & i_pin_in[`BIT_T0_CNT_RESET];

	// Plain I/O by direction, compare outputs override bits 7 and 6
	always @* begin
		o_pin_out = i_data; // [R1] [R14]
		o_pin_oe  = i_dir; // [R1] [R14]
		if (t1_cmp_on) begin
			o_pin_out[`BIT_T1_COMPARE] = i_t1_compare_out;
			o_pin_oe[`BIT_T1_COMPARE]  = 1'b1;
		end
		if (t0_cmp_on) begin
			o_pin_out[`BIT_T0_COMPARE] = i_t0_compare_out;
			o_pin_oe[`BIT_T0_COMPARE]  = 1'b1;
		end
		o_function = `PORT_RESET;
		o_function[`BIT_T1_COMPARE]   = t1_cmp_on;
		o_function[`BIT_T0_COMPARE]   = t0_cmp_on;
		o_function[`BIT_T1_EXT_CLOCK] = t1_clk_on;
		o_function[`BIT_T1_CNT_RESET] = t1_rst_on;
		o_function[`BIT_T0_EXT_CLOCK] = t0_clk_on;
		o_function[`BIT_T0_CNT_RESET] = t0_rst_on;
	end

endmodule // timer_pin_mux

// ### port_pin_state_io_timer_pins.v
// Behaviour
// [R1] Direction bit 1 drives the pin, 0 makes it an input.
// [R2] Direction register is write-only; reads return no stored bits.
// [R3] Software writes the whole direction byte, never bit read-modify-write.
// [R4] Direction clears on power-on reset and hardware standby, kept otherwise.
// [R5] Output data register is read/write and drives the output pins.
// [R6] Output data clears on power-on reset and hardware standby, kept otherwise.
// [R7] Pin-state read gives output data where output, pin level where input.
// [R8] Pin-state register is read-only; writes are ignored.
// [R9] Pin state follows pins after power-on; frozen in manual reset, software standby.
// [R10] Manual reset drops timer functions; pins follow direction and data only.
// [R11] Bits 7 and 6 drive timer compare outputs when output-select nonzero.
// [R12] Bits 5 and 3 feed timer clocks when external clock selected.
// [R13] Bits 4 and 2 feed counter resets when both clear bits set.
// [R14] Bits 1 and 0 are plain I/O only.
`include "port_pin_state_defs.vh"

module port_pin_state_io_timer_pins (
	// Clock and reset
	input  wire                     i_ref_clk,
	input  wire                     i_sys_rst,
	// Operating states
	input  wire                     i_manual_rst,
	input  wire                     i_hw_standby,
	input  wire                     i_sw_standby,
	// Avalon-MM slave
	input  wire [`AVS_ADDR_W-1:0]   i_avs_address,
	input  wire                     i_avs_read,
	input  wire                     i_avs_write,
	input  wire [`AVS_DATA_W-1:0]   i_avs_writedata,
	output wire                     o_avs_waitrequest,
	output wire [`AVS_DATA_W-1:0]   o_avs_readdata,
	// Port pins
	input  wire [`PORT_W-1:0]       i_port_pin_in,
	output wire [`PORT_W-1:0]       o_port_pin_out,
	output wire [`PORT_W-1:0]       o_port_pin_oe,
	// Timer settings
	input  wire [`OS_W-1:0]         i_timer0_output_select_field,
	input  wire [`OS_W-1:0]         i_timer1_output_select_field,
	input  wire [`CKS_W-1:0]        i_timer0_clock_select_field,
	input  wire [`CKS_W-1:0]        i_timer1_clock_select_field,
	input  wire [`CCLR_W-1:0]       i_timer0_counter_clear,
	input  wire [`CCLR_W-1:0]       i_timer1_counter_clear,
	input  wire                     i_timer0_compare_out,
	input  wire                     i_timer1_compare_out,
	// Timer inputs from pins
	output wire                     o_timer0_ext_clock_in,
	output wire                     o_timer1_ext_clock_in,
	output wire                     o_timer0_counter_reset_in,
	output wire                     o_timer1_counter_reset_in
);

	reg  [`PORT_W-1:0] port_direction_reg;
	reg  [`PORT_W-1:0] port_output_data_reg;
	reg  [`PORT_W-1:0] pin_sample_reg;
	reg  [`PORT_W-1:0] pin_out_reg;
	reg  [`PORT_W-1:0] pin_oe_reg;
	reg  [`PORT_W-1:0] function_reg;
	reg                t0_clk_reg;
	reg                t1_clk_reg;
	reg                t0_rst_reg;
	reg                t1_rst_reg;
	wire [`PORT_W-1:0] port_pin_state;
	wire [`PORT_W-1:0] mux_out;
	wire [`PORT_W-1:0] mux_oe;
	wire [`PORT_W-1:0] mux_function;
	wire               mux_t0_clk;
	wire               mux_t1_clk;
	wire               mux_t0_rst;
	wire               mux_t1_rst;
	wire               dir_we;
	wire               data_we;
	wire [`PORT_W-1:0] wr_byte;
	wire               timers_live;
	wire               clear_regs;

	assign clear_regs  = i_sys_rst | i_hw_standby;
	assign timers_live = ~i_manual_rst & ~i_hw_standby; // [R10]

	// Per bit: data where output, sampled pin where input
	assign port_pin_state = (port_direction_reg & port_output_data_reg)
		| (~port_direction_reg & pin_sample_reg); // [R7]

	avalon_port_slave u_slave (
		.i_ref_clk         (i_ref_clk),
		.i_sys_rst         (i_sys_rst),
		.i_avs_address     (i_avs_address),
		.i_avs_read        (i_avs_read),
		.i_avs_write       (i_avs_write),
		.i_avs_writedata   (i_avs_writedata),
		.o_avs_waitrequest (o_avs_waitrequest),
		.o_avs_readdata    (o_avs_readdata),
		.i_pin_state       (port_pin_state),
		.i_output_data     (port_output_data_reg),
		.i_pin_function    (function_reg),
		.o_dir_we          (dir_we),
		.o_data_we         (data_we),
		.o_wr_byte         (wr_byte)
	);

	timer_pin_mux u_mux (
		.i_dir              (port_direction_reg),
		.i_data             (port_output_data_reg),
		.i_pin_in           (i_port_pin_in),
		.i_timers_live      (timers_live),
		.i_t0_output_select (i_timer0_output_select_field),
		.i_t1_output_select (i_timer1_output_select_field),
		.i_t0_clock_select  (i_timer0_clock_select_field),
		.i_t1_clock_select  (i_timer1_clock_select_field),
		.i_t0_counter_clear (i_timer0_counter_clear),
		.i_t1_counter_clear (i_timer1_counter_clear),
		.i_t0_compare_out   (i_timer0_compare_out),
		.i_t1_compare_out   (i_timer1_compare_out),
		.o_pin_out          (mux_out),
		.o_pin_oe           (mux_oe),
		.o_function         (mux_function),
		.o_t0_ext_clock     (mux_t0_clk),
		.o_t1_ext_clock     (mux_t1_clk),
		.o_t0_cnt_reset     (mux_t0_rst),
		.o_t1_cnt_reset     (mux_t1_rst)
	);

	// Direction and output data, kept through manual reset and sw standby
	always @(posedge i_ref_clk) begin
		if (clear_regs) begin
			port_direction_reg   <= `PORT_RESET; // [R4]
			port_output_data_reg <= `PORT_RESET; // [R6]
		end else begin
			if (dir_we) begin
				port_direction_reg <= wr_byte; // [R1] [R3]
			end
			if (data_we) begin
				port_output_data_reg <= wr_byte; // [R5]
			end
		end
	end

	// Pin sampling, frozen in manual reset and software standby
	always @(posedge i_ref_clk) begin
		if (clear_regs) begin
			pin_sample_reg <= i_port_pin_in; // [R9]
		end else if (!i_manual_rst && !i_sw_standby) begin
			pin_sample_reg <= i_port_pin_in; // [R9]
		end
	end

	// Registered pin drive and timer inputs
	always @(posedge i_ref_clk) begin
		if (clear_regs) begin
			pin_out_reg  <= `PORT_RESET;
			pin_oe_reg   <= `PORT_RESET;
			function_reg <= `PORT_RESET;
			t0_clk_reg   <= 1'b0;
			t1_clk_reg   <= 1'b0;
			t0_rst_reg   <= 1'b0;
			t1_rst_reg   <= 1'b0;
		end else begin
			pin_out_reg  <= mux_out; // [R11] [R14]
			pin_oe_reg   <= mux_oe; // [R1]
			function_reg <= mux_function;
			t0_clk_reg   <= mux_t0_clk; // [R12]
			t1_clk_reg   <= mux_t1_clk; // [R12]
			t0_rst_reg   <= mux_t0_rst; // [R13]
			t1_rst_reg   <= mux_t1_rst; // [R13]
		end
	end

	assign o_port_pin_out            = pin_out_reg;
	assign o_port_pin_oe             = pin_oe_reg;
	assign o_timer0_ext_clock_in     = t0_clk_reg;
	assign o_timer1_ext_clock_in     = t1_clk_reg;
	assign o_timer0_counter_reset_in = t0_rst_reg;
	assign o_timer1_counter_reset_in = t1_rst_reg;

endmodule // port_pin_state_io_timer_pins

// ### pin_board_model.sv
module pin_board_model (
	// Port side
	input  wire logic [7:0]	i_pin_out,
	input  wire logic [7:0]	i_pin_oe,
	// Board side
	input  wire logic [7:0]	i_board,
	output logic [7:0]	o_pin_level
);
	timeunit 1ns;
	timeprecision 100ps;
	// Driven bits show the port, the others the board
	assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_board);
endmodule // pin_board_model

// ### port_pin_state_pins_chk.sv
module port_pin_state_pins_chk (
	// Clock, reset, states
	input wire		i_ref_clk,
	input wire		i_sys_rst,
	input wire		i_manual_rst,
	input wire		i_hw_standby,
	// Bus
	input wire [17:0]	i_avs_address,
	input wire		i_avs_read,
	input wire		i_avs_write,
	input wire [31:0]	i_avs_writedata,
	input wire		o_avs_waitrequest,
	input wire [31:0]	o_avs_readdata,
	// Pins and timers
	input wire [7:0]	i_port_pin_in,
	input wire [7:0]	o_port_pin_out,
	input wire [7:0]	o_port_pin_oe,
	input wire [3:0]	i_timer0_output_select_field,
	input wire [3:0]	i_timer1_output_select_field,
	input wire [2:0]	i_timer1_clock_select_field,
	input wire [1:0]	i_timer0_counter_clear,
	input wire		i_timer0_compare_out,
	input wire		i_timer1_compare_out,
	input wire		o_timer0_ext_clock_in,
	input wire		o_timer1_ext_clock_in,
	input wire		o_timer0_counter_reset_in,
	input wire		o_timer1_counter_reset_in
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	wire dir_wr;
	wire live;
	assign dir_wr = i_avs_write && !o_avs_waitrequest && !i_hw_standby
		&& i_avs_address == 18'h3FAC4;
	assign live = !i_manual_rst && !i_hw_standby;
	plain_oe_a: assert property (dir_wr ##1 (!i_hw_standby)[*2]
		|-> o_port_pin_oe[1:0] == $past(i_avs_writedata[1:0], 2)) else $error("plain oe");
	cmp_hi_a: assert property (live && i_timer1_output_select_field != 4'h0
		|=> o_port_pin_oe[7] && o_port_pin_out[7] == $past(i_timer1_compare_out))
		else $error("bit7 compare");
	cmp_lo_a: assert property (live && i_timer0_output_select_field != 4'h0
		|=> o_port_pin_oe[6] && o_port_pin_out[6] == $past(i_timer0_compare_out))
		else $error("bit6 compare");
	ext_clk_a: assert property (live && i_timer1_clock_select_field >= 3'h5
		|=> o_timer1_ext_clock_in == $past(i_port_pin_in[5])) else $error("ext clock");
	cnt_rst_a: assert property (live && i_timer0_counter_clear == 2'h3
		|=> o_timer0_counter_reset_in == $past(i_port_pin_in[2])) else $error("cnt reset");
	manual_off_a: assert property (i_manual_rst |=> !(o_timer0_ext_clock_in
		|| o_timer1_ext_clock_in || o_timer0_counter_reset_in
		|| o_timer1_counter_reset_in)) else $error("timer inputs live");
	hw_release_a: assert property (i_hw_standby |=> o_port_pin_oe == 8'h00)
		else $error("pins driven");
	dir_read_a: assert property (i_avs_read && !o_avs_waitrequest
		&& i_avs_address == 18'h3FAC4 |-> o_avs_readdata == 32'h00000000)
		else $error("dir read");
endmodule // port_pin_state_pins_chk

bind port_pin_state_io_timer_pins port_pin_state_pins_chk u_port_pin_state_pins_chk (.i_ref_clk, .i_sys_rst,
	.i_manual_rst, .i_hw_standby, .i_avs_address, .i_avs_read, .i_avs_write,
	.i_avs_writedata, .o_avs_waitrequest, .o_avs_readdata, .i_port_pin_in,
	.o_port_pin_out, .o_port_pin_oe, .i_timer0_output_select_field,
	.i_timer1_output_select_field, .i_timer1_clock_select_field, .i_timer0_counter_clear,
	.i_timer0_compare_out, .i_timer1_compare_out, .o_timer0_ext_clock_in,
	.o_timer1_ext_clock_in, .o_timer0_counter_reset_in, .o_timer1_counter_reset_in);

// ### port_pin_state_io_timer_pins_tb.sv
module port_pin_state_io_timer_pins_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_ref_clk, i_sys_rst, i_manual_rst, i_hw_standby, i_sw_standby;
	logic i_avs_read, i_avs_write, o_avs_waitrequest, i_timer0_compare_out;
	logic i_timer1_compare_out, o_timer0_ext_clock_in, o_timer1_ext_clock_in;
	logic o_timer0_counter_reset_in, o_timer1_counter_reset_in;
	logic [17:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata;
	logic [7:0] i_port_pin_in, o_port_pin_out, o_port_pin_oe, board, got;
	logic [3:0] i_timer0_output_select_field, i_timer1_output_select_field;
	logic [2:0] i_timer0_clock_select_field, i_timer1_clock_select_field;
	logic [1:0] i_timer0_counter_clear, i_timer1_counter_clear;
	int err_count, checks_done;
	localparam logic [17:0] a_dir = 18'h3FAC4, a_pin = 18'h3FD44, a_dat = 18'h3FD84;
	localparam logic [17:0] a_fn = 18'h3FDC4;

	port_pin_state_io_timer_pins u_port_pin_state_io_timer_pins (.i_ref_clk, .i_sys_rst, .i_manual_rst,
		.i_hw_standby, .i_sw_standby, .i_avs_address, .i_avs_read, .i_avs_write,
		.i_avs_writedata, .o_avs_waitrequest, .o_avs_readdata, .i_port_pin_in,
		.o_port_pin_out, .o_port_pin_oe, .i_timer0_output_select_field,
		.i_timer1_output_select_field, .i_timer0_clock_select_field,
		.i_timer1_clock_select_field, .i_timer0_counter_clear, .i_timer1_counter_clear,
		.i_timer0_compare_out, .i_timer1_compare_out, .o_timer0_ext_clock_in,
		.o_timer1_ext_clock_in, .o_timer0_counter_reset_in, .o_timer1_counter_reset_in);
	pin_board_model u_pin_board_model (.i_pin_out(o_port_pin_out), .i_pin_oe(o_port_pin_oe),
		.i_board(board), .o_pin_level(i_port_pin_in));

	initial begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One access; request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic r, input logic [17:0] a, input logic [7:0] d);
		int n;
		n = 0;
		i_avs_read <= r;
		i_avs_write <= !r;
		i_avs_address <= a;
		i_avs_writedata <= {24'h000000, d};
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 40);
		if (o_avs_waitrequest !== 1'b0) begin
			err_count++;
			wrap_up();
		end
		got = o_avs_readdata[7:0];
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		@(posedge i_ref_clk);
	endtask

	task automatic rdc(input string nm, input logic [17:0] a, input logic [7:0] e);
		bus(1'b1, a, 8'h00);
		chk(nm, got, e);
	endtask

	initial begin
		{i_avs_read, i_avs_write, i_manual_rst, i_hw_standby, i_sw_standby} = '0;
		{i_timer0_compare_out, i_timer1_compare_out, i_avs_address, i_avs_writedata} = '0;
		{i_timer0_output_select_field, i_timer1_output_select_field} = '0;
		{i_timer0_clock_select_field, i_timer1_clock_select_field} = '0;
		{i_timer0_counter_clear, i_timer1_counter_clear} = '0;
		board = 8'hA5;
		i_sys_rst = 1'b1;
		repeat (16) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_ref_clk);
		rdc("data_rst", a_dat, 8'h00);
		rdc("pin_rst", a_pin, 8'hA5);
		bus(1'b0, a_dir, 8'hF0);
		bus(1'b0, a_dat, 8'h3C);
		bus(1'b0, a_pin, 8'hFF);
		bus(1'b0, 18'h00010, 8'hFF);
		rdc("data", a_dat, 8'h3C);
		rdc("pin_mix", a_pin, 8'h35);
		rdc("dir_rd", a_dir, 8'h00);
		rdc("unmapped", 18'h00010, 8'h00);
		chk("oe", o_port_pin_oe, 8'hF0);
		chk("out", o_port_pin_out & 8'hF0, 8'h30);
		// Timer functions on, all direction bits input, compare outputs drive bits 7 and 6
		bus(1'b0, a_dir, 8'h00);
		i_timer1_output_select_field <= 4'h8;
		i_timer0_output_select_field <= 4'h1;
		i_timer1_compare_out <= 1'b1;
		i_timer0_compare_out <= 1'b1;
		i_timer1_clock_select_field <= 3'h5;
		i_timer0_counter_clear <= 2'h3;
		repeat (3) @(posedge i_ref_clk);
		chk("cmp_oe", o_port_pin_oe, 8'hC0);
		chk("cmp_out", o_port_pin_out & 8'hC0, 8'hC0);
		chk("tin_a", {4'h0, o_timer1_ext_clock_in, o_timer0_ext_clock_in,
			o_timer1_counter_reset_in, o_timer0_counter_reset_in}, 8'h09);
		board <= 8'h5A;
		i_timer0_clock_select_field <= 3'h7;
		i_timer1_counter_clear <= 2'h3;
		repeat (3) @(posedge i_ref_clk);
		chk("tin_b", {4'h0, o_timer1_ext_clock_in, o_timer0_ext_clock_in,
			o_timer1_counter_reset_in, o_timer0_counter_reset_in}, 8'h06);
		rdc("func", a_fn, 8'hFC);
		// Manual reset keeps registers, drops timers, freezes the sample
		bus(1'b0, a_dir, 8'h0F);
		i_manual_rst <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		board <= 8'hC3;
		repeat (2) @(posedge i_ref_clk);
		chk("man_tin", {4'h0, o_timer1_ext_clock_in, o_timer0_ext_clock_in,
			o_timer1_counter_reset_in, o_timer0_counter_reset_in}, 8'h00);
		chk("man_oe", o_port_pin_oe, 8'h0F);
		// Frozen sample holds the compare levels on bits 7 and 6
		rdc("man_pin", a_pin, 8'hDC);
		i_manual_rst <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_sw_standby <= 1'b1;
		@(posedge i_ref_clk);
		board <= 8'h00;
		repeat (2) @(posedge i_ref_clk);
		rdc("sw_pin", a_pin, 8'hCC);
		chk("sw_oe", o_port_pin_oe & 8'h3F, 8'h0F);
		i_sw_standby <= 1'b0;
		i_hw_standby <= 1'b1;
		board <= 8'h96;
		repeat (2) @(posedge i_ref_clk);
		chk("hw_oe", o_port_pin_oe, 8'h00);
		i_hw_standby <= 1'b0;
		@(posedge i_ref_clk);
		rdc("hw_dat", a_dat, 8'h00);
		// Compare outputs drive bits 7 and 6 again once standby ends
		rdc("hw_pin", a_pin, 8'hD6);
		wrap_up();
	end
endmodule // port_pin_state_io_timer_pins_tb
